/* rtl/scsi_transfer_control_one.sv */
// Transfer control register 1 of the bus module with the logic it steers:
// discard transfers, bus parity check, selection timer, active negation
// and termination power control.
// Assumes a classic Wishbone master on clk_i; bus pins arrive unsynchronised,
// sequencer and data path signals are on clk_i.
//
// How it works
// - Discard mode in initiator mode drops read data and sends 00h.
// - Discard mode in initiator mode stores nothing and never stalls on buffer full/empty.
// - Parity checked in selection, reselection and information phases.
// - Parity error with checking enabled sets the parity error flag.
// - Parity error with checking and auto attention enabled drives ATN active.
// - Parity error flag reads zero while checking is disabled.
// - Bits 4:3 choose timeout; alternate bit picks normal or alternate set.
// - Normal set: 256, 128, 64, 32 ms.
// - Alternate set: 256, 4, 2, 1 ms.
// - Timer expiry with timeout enabled starts a soft selection abort.
// - No BSY during abort sets selection timeout flag and ends attempt.
// - Timeout disabled: attempt runs until BSY answers or the sequencer stops it.
// - Active negation drives all outputs except RESET, BSY and SEL.
// - Active negation off during configuration protocol or when unconnected.
// - Termination power output takes chosen polarity when enabled.
`include "xfer_ctrl_consts.svh"
module scsi_transfer_control_one
  import xfer_ctrl_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `XC_MS_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  output logic                       irq_o,
  // Bus pins (asynchronous)
  input  wire xfer_ctrl_pkg::bus_byte_s bus_byte_i,
  input  wire logic                  bus_bsy_i,
  // Sequencer and data path (clk_i domain)
  input  wire logic                  initiator_mode_i,
  input  wire logic                  selection_phase_i,
  input  wire logic                  info_phase_i,
  input  wire logic                  bus_sample_i,
  input  wire logic                  data_in_dir_i,
  input  wire logic [7:0]            buffer_data_i,
  input  wire logic                  buffer_full_i,
  input  wire logic                  buffer_empty_i,
  input  wire logic                  sel_start_i,
  input  wire logic                  sel_stop_i,
  input  wire logic                  atn_clear_i,
  input  wire logic                  connected_i,
  input  wire logic                  config_protocol_i,
  // Outputs
  output logic [7:0]                 bus_data_out_o,
  output logic                       buffer_write_o,
  output logic                       transfer_stall_o,
  output logic                       discard_active_o,
  output logic                       atn_assert_o,
  output logic                       selection_active_o,
  output logic                       selection_abort_o,
  output logic                       selection_won_o,
  output logic                       active_negation_o,
  output logic                       termination_power_output_o
);

  typedef logic [8:0] ms_t;

  // Register state
  xfer_ctrl1_s ctrl_q;
  logic [2:0]  aux_q;
  logic [1:0]  status_q;
  logic [1:0]  mask_q;
  logic        ack_q;
  logic [31:0] rdata_q;

  // Synchronisers for bus pins
  bus_byte_s   byte_meta_q;
  bus_byte_s   byte_sync_q;
  logic        bsy_meta_q;
  logic        bsy_sync_q;

  // Selection timer
  sel_state_e  sel_state_q;
  logic [13:0] tick_cnt_q;
  ms_t         ms_cnt_q;
  logic [13:0] abort_cnt_q;
  logic        sel_won_q;

  // Registered outputs
  logic [7:0]  data_out_q;
  logic        buf_wr_q;
  logic        stall_q;
  logic        discard_q;
  logic        atn_q;
  logic        actneg_q;
  logic        tpwr_q;

  // Bus decode
  wire         bus_req    = cyc_i & stb_i & ~ack_q;
  wire         wr_req     = bus_req & we_i & sel_i[0];
  wire  [5:0]  reg_idx    = adr_i[7:2];
  wire         hit_ctrl1  = reg_idx == `XC_IDX_XFER_CTRL1;
  wire         hit_aux    = reg_idx == `XC_IDX_AUX_CTRL;
  wire         hit_status = reg_idx == `XC_IDX_IRQ_STATUS;
  wire         hit_mask   = reg_idx == `XC_IDX_IRQ_MASK;
  wire         hit_state  = reg_idx == `XC_IDX_BUS_STATE;

  // Mode decode
  wire         discard_on  = ctrl_q.discard_mode & initiator_mode_i;
  wire         check_phase = selection_phase_i | info_phase_i;
  wire         parity_bad  = ^{byte_sync_q.data, byte_sync_q.parity} == 1'b0;
  wire         parity_err  = ctrl_q.parity_check_enable & check_phase &
                             bus_sample_i & parity_bad;
  wire         alt_timing  = aux_q[`XC_AUX_ALT_TIMEOUT];

  // Timeout delay lookup
  function automatic ms_t delay_ms(input logic alt, input logic [1:0] code);
    ms_t r;
    r = ms_t'(`XC_TMO_NORM_0);
    case ({alt, code})
      3'b000:  r = ms_t'(`XC_TMO_NORM_0);
      3'b001:  r = ms_t'(`XC_TMO_NORM_1);
      3'b010:  r = ms_t'(`XC_TMO_NORM_2);
      3'b011:  r = ms_t'(`XC_TMO_NORM_3);
      3'b100:  r = ms_t'(`XC_TMO_ALT_0);
      3'b101:  r = ms_t'(`XC_TMO_ALT_1);
      3'b110:  r = ms_t'(`XC_TMO_ALT_2);
      3'b111:  r = ms_t'(`XC_TMO_ALT_3);
      default: r = ms_t'(`XC_TMO_NORM_0);
    endcase
    return r;
  endfunction

  wire  ms_t   delay_lim = delay_ms(alt_timing,
                                    ctrl_q.timeout_delay_select);
  wire         ms_tick   = tick_cnt_q == 14'(MS_CYCLES - 1);
  wire         expired   = ms_tick & (ms_cnt_q == delay_lim - 9'h001);
  wire         abort_end = abort_cnt_q == 14'(`XC_ABORT_CYCLES - 1);
  wire         sel_fail  = (sel_state_q == SEL_ABORT) & abort_end &
                           ~bsy_sync_q;

  // Status events and clear
  wire  [1:0]  events;
  assign events[`XC_IRQ_PARITY]      = parity_err;
  assign events[`XC_IRQ_SEL_TIMEOUT] = sel_fail;
  wire  [1:0]  clr_bits  = (wr_req & hit_status) ? dat_i[1:0] : 2'h0;
  wire  [1:0]  status_d  = (status_q & ~clr_bits) | events;
  wire  [1:0]  status_rd = {status_q[1],
                            status_q[0] & ctrl_q.parity_check_enable};

  // Read mux
  wire  [7:0]  rd_byte =
    hit_ctrl1  ? {ctrl_q[7], 1'b0, ctrl_q[5:0]} :
    hit_aux    ? {5'h00, aux_q} :
    hit_status ? {6'h00, status_rd} :
    hit_mask   ? {6'h00, mask_q} :
    hit_state  ? {3'h0, sel_won_q, atn_q, selection_abort_o,
                  selection_active_o, bsy_sync_q} :
                 8'h00;

  // Data path decode
  wire         buf_wr_d  = bus_sample_i & data_in_dir_i & info_phase_i &
                           ~discard_on;
  wire         stall_d   = ~discard_on &
                           (data_in_dir_i ? buffer_full_i
                                          : buffer_empty_i);
  wire  [7:0]  data_out_d = discard_on ? 8'h00 : buffer_data_i;
  wire         actneg_d  = ctrl_q.active_negation_enable & connected_i &
                           ~config_protocol_i;
  wire         tpwr_pol  = aux_q[`XC_AUX_TPWR_POL];
  wire         tpwr_d    = ctrl_q.termination_power_enable ? tpwr_pol
                                                           : ~tpwr_pol;
  wire         atn_set   = parity_err & aux_q[`XC_AUX_AUTO_ATN];

  // Wishbone slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= bus_req;
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= xfer_ctrl1_s'(`XC_XFER_CTRL1_RESET);
      aux_q  <= `XC_AUX_RESET;
      mask_q <= `XC_IRQ_RESET;
    end else if (wr_req) begin
      if (hit_ctrl1) begin
        ctrl_q <= xfer_ctrl1_s'(dat_i[7:0] & `XC_XFER_CTRL1_WMASK);
      end
      if (hit_aux) begin
        aux_q <= dat_i[2:0];
      end
      if (hit_mask) begin
        mask_q <= dat_i[1:0];
      end
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= `XC_IRQ_RESET;
      irq_o    <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_o    <= |(status_d & mask_q);
    end
  end

  // Two-flop synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_meta_q <= '0;
      byte_sync_q <= '0;
      bsy_meta_q  <= 1'b0;
      bsy_sync_q  <= 1'b0;
    end else begin
      byte_meta_q <= bus_byte_i;
      byte_sync_q <= byte_meta_q;
      bsy_meta_q  <= bus_bsy_i;
      bsy_sync_q  <= bsy_meta_q;
    end
  end

  // Selection timer and soft abort
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_state_q <= SEL_IDLE;
      tick_cnt_q  <= 14'h0000;
      ms_cnt_q    <= 9'h000;
      abort_cnt_q <= 14'h0000;
      sel_won_q   <= 1'b0;
    end else begin
      case (sel_state_q)
        SEL_IDLE: begin
          tick_cnt_q  <= 14'h0000;
          ms_cnt_q    <= 9'h000;
          abort_cnt_q <= 14'h0000;
          if (sel_start_i) begin
            sel_state_q <= SEL_RUN;
            sel_won_q   <= 1'b0;
          end
        end
        SEL_RUN: begin
          tick_cnt_q <= ms_tick ? 14'h0000 : tick_cnt_q + 14'h0001;
          if (ms_tick) begin
            ms_cnt_q <= ms_cnt_q + 9'h001;
          end
          if (sel_stop_i) begin
            sel_state_q <= SEL_IDLE;
          end else if (bsy_sync_q) begin
            sel_state_q <= SEL_IDLE;
            sel_won_q   <= 1'b1;
          end else if (ctrl_q.selection_timeout_enable & expired) begin
            sel_state_q <= SEL_ABORT;
          end
        end
        SEL_ABORT: begin
          abort_cnt_q <= abort_cnt_q + 14'h0001;
          if (sel_stop_i) begin
            sel_state_q <= SEL_IDLE;
          end else if (bsy_sync_q) begin
            sel_state_q <= SEL_IDLE;
            sel_won_q   <= 1'b1;
          end else if (abort_end) begin
            sel_state_q <= SEL_IDLE;
          end
        end
        default: sel_state_q <= SEL_IDLE;
      endcase
    end
  end

  // Data path, attention and driver controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_out_q <= 8'h00;
      buf_wr_q   <= 1'b0;
      stall_q    <= 1'b0;
      discard_q  <= 1'b0;
      atn_q      <= 1'b0;
      actneg_q   <= 1'b0;
      tpwr_q     <= 1'b1;
    end else begin
      data_out_q <= data_out_d;
      buf_wr_q   <= buf_wr_d;
      stall_q    <= stall_d;
      discard_q  <= discard_on;
      atn_q      <= atn_set | (atn_q & ~atn_clear_i);
      actneg_q   <= actneg_d;
      tpwr_q     <= tpwr_d;
    end
  end

  assign dat_o                      = rdata_q;
  assign ack_o                      = ack_q;
  assign bus_data_out_o             = data_out_q;
  assign buffer_write_o             = buf_wr_q;
  assign transfer_stall_o           = stall_q;
  assign discard_active_o           = discard_q;
  assign atn_assert_o               = atn_q;
  assign selection_active_o         = sel_state_q != SEL_IDLE;
  assign selection_abort_o          = sel_state_q == SEL_ABORT;
  assign selection_won_o            = sel_won_q;
  assign active_negation_o          = actneg_q;
  assign termination_power_output_o = tpwr_q;

endmodule

/* shared/xfer_ctrl_consts.svh */
// Offsets, field positions, reset values and timing figures of the
// transfer control block. Included by the package and the design.
`ifndef XFER_CTRL_CONSTS_SVH
`define XFER_CTRL_CONSTS_SVH

// Register indices; byte address is four times the index
`define XC_IDX_XFER_CTRL1   6'h02
`define XC_IDX_AUX_CTRL     6'h03
`define XC_IDX_IRQ_STATUS   6'h04
`define XC_IDX_IRQ_MASK     6'h05
`define XC_IDX_BUS_STATE    6'h06

`define XC_XFER_CTRL1_RESET 8'h00
`define XC_XFER_CTRL1_WMASK 8'hbf

// Bits of the auxiliary control register
`define XC_AUX_AUTO_ATN     0
`define XC_AUX_ALT_TIMEOUT  1
`define XC_AUX_TPWR_POL     2
`define XC_AUX_RESET        3'h0

// Bits of the status and mask registers
`define XC_IRQ_PARITY       0
`define XC_IRQ_SEL_TIMEOUT  1
`define XC_IRQ_RESET        2'h0

// Timing
`define XC_CLK_HZ           10000000
`define XC_MS_CYCLES        (`XC_CLK_HZ / 1000)
`define XC_ABORT_WAIT_US    200
`define XC_ABORT_CYCLES     ((`XC_ABORT_WAIT_US * `XC_CLK_HZ) / 1000000)

// Selection timeout delays in milliseconds
`define XC_TMO_NORM_0       256
`define XC_TMO_NORM_1       128
`define XC_TMO_NORM_2       64
`define XC_TMO_NORM_3       32
`define XC_TMO_ALT_0        256
`define XC_TMO_ALT_1        4
`define XC_TMO_ALT_2        2
`define XC_TMO_ALT_3        1

`endif

/* shared/xfer_ctrl_pkg.sv */
// Types shared by the transfer control block and its bench.
// Assumes the constants header is on the include path.
package xfer_ctrl_pkg;
  `include "xfer_ctrl_consts.svh"

  typedef struct packed {
    logic       discard_mode;
    logic       reserved;
    logic       parity_check_enable;
    logic [1:0] timeout_delay_select;
    logic       selection_timeout_enable;
    logic       active_negation_enable;
    logic       termination_power_enable;
  } xfer_ctrl1_s;

  typedef struct packed {
    logic [7:0] data;
    logic       parity;
  } bus_byte_s;

  typedef enum logic [1:0] {
    SEL_IDLE  = 2'b00,
    SEL_RUN   = 2'b01,
    SEL_ABORT = 2'b10
  } sel_state_e;
endpackage

/* tb/bus_target_model.sv */
// Far-side bus device: drives a byte with odd parity and answers BSY.
// Tasks are called from clk_i-synchronous bench code.
module bus_target_model
  import xfer_ctrl_pkg::*;
(
  input  wire logic                clk_i,
  output xfer_ctrl_pkg::bus_byte_s bus_byte_o,
  output logic                     bus_bsy_o
);
  logic      driving_q;
  bus_byte_s held_q;
  initial begin
    {driving_q, held_q, bus_byte_o, bus_bsy_o} = '0;
  end
  // Released byte lines change every cycle
  always @(posedge clk_i) begin
    bus_byte_o <= driving_q ? held_q : ~bus_byte_o;
  end
  task automatic drive_byte(input logic [7:0] d, input logic bad);
    @(posedge clk_i);
    held_q <= '{d, ~^d ^ bad};
    driving_q <= 1'b1;
  endtask
  task automatic release_bus();
    @(posedge clk_i);
    driving_q <= 1'b0;
  endtask
  task automatic answer_bsy(input int dly);
    repeat (dly) @(posedge clk_i);
    bus_bsy_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    bus_bsy_o <= 1'b0;
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench of the transfer control block.
// Needs the package, the design, the checker and the bus model.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import xfer_ctrl_pkg::*;
  localparam int MS = 10;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 0, buffer_data_i = 0, bus_data_out_o;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, rd;
  logic initiator_mode_i = 0, selection_phase_i = 0, info_phase_i = 0;
  logic bus_sample_i = 0, data_in_dir_i = 0, buffer_full_i = 0;
  logic buffer_empty_i = 0, sel_start_i = 0, sel_stop_i = 0;
  logic atn_clear_i = 0, connected_i = 0, config_protocol_i = 0;
  bus_byte_s bus_byte_i;
  logic bus_bsy_i, ack_o, irq_o, buffer_write_o, transfer_stall_o;
  logic discard_active_o, atn_assert_o, selection_active_o;
  logic selection_abort_o, selection_won_o, active_negation_o;
  logic termination_power_output_o;
  int fails = 0, n_tests = 0;
  int norm_ms[4] = '{256, 128, 64, 32};
  int alt_ms[4] = '{256, 4, 2, 1};

  scsi_transfer_control_one #(.MS_CYCLES(MS)) i_scsi_transfer_control_one (.*);
  bus_target_model i_model (.clk_i(clk_i), .bus_byte_o(bus_byte_i),
                            .bus_bsy_o(bus_bsy_i));

  initial forever #50 clk_i = ~clk_i;

  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wait_until(ref logic s, input logic v, input int lim,
                            output int n);
    n = 0;
    while (s !== v) begin
      if (n == lim) begin
        fails++;
        tally_and_finish();
      end
      tick(1);
      n++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'h1, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    if (n >= 40) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic pulse_start();
    sel_start_i <= 1'b1;
    tick(1);
    sel_start_i <= 1'b0;
  endtask

  task automatic t_regs();
    rdchk(8'h08, 32'h0);
    chk(termination_power_output_o, 1'b1);
    wb(1'b1, 8'h08, 8'hff);
    rdchk(8'h08, 32'hbf);
    wb(1'b1, 8'h40, 8'h5a);
    rdchk(8'h40, 32'h0);
  endtask
  task automatic t_tpwr();
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'h0c, {5'h0, i[1], 2'b00});
      wb(1'b1, 8'h08, {7'h0, i[0]});
      tick(2);
      chk(termination_power_output_o, i[0] ? i[1] : !i[1]);
      chk(termination_power_output_o == i[1], i[0]);
    end
  endtask
  task automatic t_neg();
    connected_i <= 1'b1;
    wb(1'b1, 8'h08, 8'h02);
    tick(2);
    chk(active_negation_o, 1'b1);
    config_protocol_i <= 1'b1;
    tick(2);
    chk(active_negation_o, 1'b0);
    {config_protocol_i, connected_i} <= 2'b00;
    tick(2);
    chk(active_negation_o, 1'b0);
  endtask
  task automatic t_discard();
    {initiator_mode_i, data_in_dir_i, buffer_full_i} <= 3'b111;
    {info_phase_i, bus_sample_i} <= 2'b11;
    buffer_data_i <= 8'ha5;
    wb(1'b1, 8'h08, 8'h80);
    tick(2);
    chk(bus_data_out_o, 8'h00);
    chk({discard_active_o, transfer_stall_o, buffer_write_o}, 3'b100);
    wb(1'b1, 8'h08, 8'h00);
    tick(2);
    chk({buffer_write_o, transfer_stall_o, bus_data_out_o}, 10'h3a5);
    {initiator_mode_i, buffer_full_i} <= 2'b00;
    {info_phase_i, bus_sample_i} <= 2'b00;
  endtask
  task automatic send(input logic bad);
    i_model.drive_byte(8'h3c, bad);
    tick(5);
    bus_sample_i <= 1'b1;
    tick(1);
    bus_sample_i <= 1'b0;
    i_model.release_bus();
  endtask
  task automatic t_parity();
    wb(1'b1, 8'h14, 8'h03);
    wb(1'b1, 8'h0c, 8'h01);
    wb(1'b1, 8'h08, 8'h20);
    selection_phase_i <= 1'b1;
    send(1'b0);
    rdchk(8'h10, 32'h0);
    send(1'b1);
    tick(2);
    chk({irq_o, atn_assert_o}, 2'b11);
    rdchk(8'h10, 32'h1);
    wb(1'b1, 8'h08, 8'h00);
    rdchk(8'h10, 32'h0);
    wb(1'b1, 8'h10, 8'h01);
    tick(2);
    chk(irq_o, 1'b0);
    {atn_clear_i, selection_phase_i} <= 2'b10;
    tick(1);
    atn_clear_i <= 1'b0;
  endtask
  task automatic t_sel(input logic alt, input logic [1:0] code, input int ms);
    int n, m;
    wb(1'b1, 8'h0c, {6'h0, alt, 1'b0});
    wb(1'b1, 8'h08, {3'h0, code, 3'b100});
    pulse_start();
    wait_until(selection_abort_o, 1'b1, 3000, n);
    chk(n >= ms * MS - 2 && n <= ms * MS + 3, 1'b1);
    wait_until(selection_active_o, 1'b0, 2100, m);
    chk(m >= 1995 && m <= 2005, 1'b1);
    rdchk(8'h10, 32'h2);
    wb(1'b1, 8'h10, 8'h02);
  endtask
  task automatic t_bsy_and_stop();
    wb(1'b1, 8'h08, 8'h04);
    pulse_start();
    i_model.answer_bsy(20);
    tick(2);
    chk({selection_active_o, selection_won_o}, 2'b01);
    rdchk(8'h10, 32'h0);
    wb(1'b1, 8'h08, 8'h18);
    pulse_start();
    tick(600);
    chk({selection_active_o, selection_abort_o}, 2'b10);
    sel_stop_i <= 1'b1;
    tick(1);
    sel_stop_i <= 1'b0;
    tick(2);
    chk(selection_active_o, 1'b0);
  endtask

  initial begin
    tick(5);
    rst_i <= 1'b0;
    t_regs();
    t_tpwr();
    t_neg();
    t_discard();
    t_parity();
    for (int i = 0; i < 4; i++) t_sel(1'b0, i[1:0], norm_ms[i]);
    for (int i = 0; i < 4; i++) t_sel(1'b1, i[1:0], alt_ms[i]);
    t_bsy_and_stop();
    tally_and_finish();
  end
endmodule

/* tb/xfer_ctrl_monitor.sv */
// Port checker for the transfer control block.
// Bound to the top module; sees only its ports.
module xfer_ctrl_monitor (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       sel_start_i,
  input wire logic       sel_stop_i,
  input wire logic       selection_active_o,
  input wire logic       selection_abort_o,
  input wire logic       discard_active_o,
  input wire logic [7:0] bus_data_out_o,
  input wire logic       buffer_write_o,
  input wire logic       transfer_stall_o,
  input wire logic       config_protocol_i,
  input wire logic       connected_i,
  input wire logic       active_negation_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  a_discard_zero: assert property (discard_active_o |-> !bus_data_out_o)
    else $error("discard data not zero");
  a_discard_nostall: assert property (discard_active_o |-> !buffer_write_o && !transfer_stall_o)
    else $error("discard stored or stalled");
  a_sel_start: assert property (sel_start_i && !sel_stop_i && !selection_active_o |=> selection_active_o)
    else $error("selection not started");
  a_sel_stop: assert property (selection_active_o && sel_stop_i |=> !selection_active_o)
    else $error("selection not stopped");
  a_abort_inside: assert property (selection_abort_o |-> selection_active_o)
    else $error("abort outside selection");
  a_abort_after_run: assert property ($rose(selection_abort_o) |-> $past(selection_active_o))
    else $error("abort without run");
  a_negation_off: assert property (config_protocol_i || !connected_i |=> !active_negation_o)
    else $error("negation not overridden");
  c_abort: cover property ($rose(selection_abort_o));
  c_discard: cover property (discard_active_o);
  c_negation: cover property (active_negation_o);
endmodule

bind scsi_transfer_control_one xfer_ctrl_monitor i_mon (.*);
